// ### spi_master_send_control.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "spi_send_cfg.svh"

module spi_master_send_control
   import spi_send_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_clk,
   input wire logic sample_valid,
   input wire logic [7:0] sample_data,
   output logic sample_ready,
   output logic sclk,
   output logic mosi,
   output logic [`CFG_NUM_SELECTS-1:0] nss_n,
   output logic master_role
);

   bus_req_t req;
   logic send;
   mode_t mode;
   logic [7:0] burst_lsb;
   logic [12:0] burst_left;
   state_t state;
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic started;
   logic lclk_meta;
   logic lclk_sync;
   logic lclk_prev;
   logic lrise;
   logic lfall;
   logic active;
   logic kick;
   logic push;
   logic pop;
   logic take_sample;
   logic q_full;
   logic q_empty;
   logic [7:0] q_rdata;
   logic idle_flag;
   logic [7:0] rd_byte;

   // Data-phase write hit on one register index
   function automatic logic wr_hit(input bus_req_t r, input logic [7:0] idx);
      return r.valid && r.wr && (r.idx == idx);
   endfunction : wr_hit

   // Address phase is captured only when the bus moves on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req <= '0;
      end else if (hready) begin
         req.valid <= hsel && htrans[1] && (hsize == `CFG_HSIZE_WORD);
         req.wr <= hwrite;
         req.idx <= haddr[`CFG_IDX_HI:`CFG_IDX_LO];
      end
   end

   // Zero wait states and always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read mux; unused bits and unmapped words read zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (haddr[`CFG_IDX_HI:`CFG_IDX_LO])
         `CFG_IDX_SEND: rd_byte[`CFG_SEND_BIT] = send;
         `CFG_IDX_STATUS: begin
            rd_byte[`CFG_IDLE_BIT] = idle_flag;
            rd_byte[`CFG_NSS_BIT] = &nss_n;
         end
         `CFG_IDX_MODE: rd_byte = mode;
         `CFG_IDX_LSB: rd_byte = burst_lsb;
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data is sampled in the address phase so it leaves a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= {24'h00_0000, rd_byte};
      end
   end

   // Send control; only bit zero is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         send <= `CFG_SEND_RESET;
      end else if (wr_hit(req, `CFG_IDX_SEND)) begin
         send <= hwdata[`CFG_SEND_BIT];
      end
   end

   // Mode and burst length registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode.burst_msb <= `CFG_BURST_MSB_RESET;
         mode.sel <= `CFG_SEL_RESET;
         mode.role <= `CFG_ROLE_RESET;
         burst_lsb <= `CFG_LSB_RESET;
      end else begin
         if (wr_hit(req, `CFG_IDX_MODE)) begin
            mode <= mode_t'(hwdata[7:0]);
         end
         if (wr_hit(req, `CFG_IDX_LSB)) begin
            burst_lsb <= hwdata[7:0];
         end
      end
   end

   // Action writes: trigger pulse and queue push, nothing stored here
   assign kick = wr_hit(req, `CFG_IDX_KICK);
   assign push = wr_hit(req, `CFG_IDX_QUEUE);

   // Role bit leaves as a level for the pin muxing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_role <= `CFG_ROLE_RESET;
      end else begin
         master_role <= mode.role;
      end
   end

   // Outgoing mailbox; a push into a full queue is dropped
   mailbox_fifo u_mailbox (
      .clk(hclk),
      .rst_n(hresetn),
      .push(push),
      .wdata(hwdata[7:0]),
      .pop(pop),
      .rdata(q_rdata),
      .full(q_full),
      .empty(q_empty)
   );

   // Link clock comes from outside; two flops before any edge logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lclk_meta <= 1'b0;
         lclk_sync <= 1'b0;
         lclk_prev <= 1'b0;
      end else begin
         lclk_meta <= link_clk;
         lclk_sync <= lclk_meta;
         lclk_prev <= lclk_sync;
      end
   end

   assign lrise = lclk_sync && !lclk_prev;
   assign lfall = !lclk_sync && lclk_prev;

   // Master works only with send set and master role chosen
   assign active = send && mode.role;

   // Sensor byte wins only if ready is already up; a queued byte is popped before ready rises
   assign take_sample = sample_ready && sample_valid && active && (state == ST_WAIT);
   assign pop = active && (state == ST_WAIT) && !take_sample && !q_empty;

   // Burst counter; a new trigger overrides a running burst
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         burst_left <= 13'h0000;
      end else if (kick) begin
         burst_left <= {mode.burst_msb, burst_lsb};
      end else if (take_sample) begin
         burst_left <= burst_left - 13'h0001;
      end
   end

   // Ready falls in the same edge that a byte is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_ready <= 1'b0;
      end else begin
         sample_ready <= active && (state == ST_WAIT) && (burst_left != 13'h0000) &&
                         !take_sample && !pop;
      end
   end

   // Sequencer: wait for a byte, shift eight bits, back to waiting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         started <= 1'b0;
      end else if (!active) begin
         state <= ST_IDLE;
         started <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: state <= ST_WAIT;
            ST_WAIT: begin
               if (take_sample || pop) begin
                  shreg <= take_sample ? sample_data : q_rdata;
                  bitcnt <= 3'h0;
                  started <= 1'b0;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               // First falling link edge presents the leading bit
               if (lfall) begin
                  started <= 1'b1;
                  shreg <= {shreg[6:0], 1'b0};
               end else if (lrise && started) begin
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == `CFG_LAST_BIT) begin
                     state <= ST_WAIT;
                  end
               end
            end
         endcase
      end
   end

   // Data line changes on the falling link edge, MSB first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mosi <= 1'b0;
      end else if (!active) begin
         mosi <= 1'b0;
      end else if (state == ST_SHIFT && lfall) begin
         mosi <= shreg[7];
      end
   end

   // Clock pulses only while a byte is in flight; trails the link by sync delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk <= 1'b0;
      end else if (!active || lfall) begin
         sclk <= 1'b0;
      end else if (state == ST_SHIFT && started && lrise) begin
         sclk <= 1'b1;
      end
   end

   // Select follows send and the master role one flop later; reserved code drives none
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nss_n <= '1;
      end else begin
         for (int i = 0; i < `CFG_NUM_SELECTS; i++) begin
            nss_n[i] <= !(active && (mode.sel != `CFG_SEL_RESERVED) &&
                          (mode.sel == 2'(i)));
         end
      end
   end

   // Busy while shifting, or in ST_WAIT while a byte waits or a burst is unfinished
   assign idle_flag = (state == ST_IDLE) ||
                      ((state == ST_WAIT) && q_empty && (burst_left == 13'h0000));

endmodule : spi_master_send_control

`default_nettype wire

// ### spi_send_cfg.svh
`ifndef SPI_SEND_CFG_SVH
`define SPI_SEND_CFG_SVH

// Register indices; the byte address is four times the index
`define CFG_IDX_QUEUE 8'h54
`define CFG_IDX_SEND 8'h58
`define CFG_IDX_KICK 8'h59
`define CFG_IDX_STATUS 8'h5a
`define CFG_IDX_MODE 8'h5b
`define CFG_IDX_LSB 8'h5c

// Word address bits that carry the index
`define CFG_IDX_HI 9
`define CFG_IDX_LO 2

// Field positions
`define CFG_SEND_BIT 0
`define CFG_IDLE_BIT 0
`define CFG_NSS_BIT 1

// Reset values
`define CFG_SEND_RESET 1'h0
`define CFG_BURST_MSB_RESET 5'h12
`define CFG_SEL_RESET 2'h0
`define CFG_ROLE_RESET 1'h0
`define CFG_LSB_RESET 8'h00

// Target selection code that drives no select line
`define CFG_SEL_RESERVED 2'h3
`define CFG_NUM_SELECTS 3

// Shifting and queue
`define CFG_LAST_BIT 3'h7
`define CFG_FIFO_DEPTH 8
`define CFG_FIFO_AW 3

// Bus encodings
`define CFG_HSIZE_WORD 3'h2

`endif

// ### spi_send_pkg.sv
package spi_send_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_SHIFT
   } state_t;

   // Captured address phase of the register bus
   typedef struct packed {
      logic valid;
      logic wr;
      logic [7:0] idx;
   } bus_req_t;

   // Master mode register layout
   typedef struct packed {
      logic [4:0] burst_msb;
      logic [1:0] sel;
      logic role;
   } mode_t;

endpackage : spi_send_pkg

// ### mailbox_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_send_cfg.svh"

module mailbox_fifo (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [7:0] wdata,
   input wire logic pop,
   output logic [7:0] rdata,
   output logic full,
   output logic empty
);

   logic [7:0] mem [0:`CFG_FIFO_DEPTH-1];
   logic [`CFG_FIFO_AW:0] wptr;
   logic [`CFG_FIFO_AW:0] rptr;

   // Extra pointer bit tells full from empty
   assign empty = (wptr == rptr);
   assign full = (wptr[`CFG_FIFO_AW] != rptr[`CFG_FIFO_AW]) &&
                 (wptr[`CFG_FIFO_AW-1:0] == rptr[`CFG_FIFO_AW-1:0]);
   assign rdata = mem[rptr[`CFG_FIFO_AW-1:0]];

   // Storage has no reset; only the pointers matter
   always_ff @(posedge clk) begin
      if (push && !full) begin
         mem[wptr[`CFG_FIFO_AW-1:0]] <= wdata;
      end
   end

   // Write pointer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr <= '0;
      end else if (push && !full) begin
         wptr <= wptr + 1'b1;
      end
   end

   // Read pointer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rptr <= '0;
      end else if (pop && !empty) begin
         rptr <= rptr + 1'b1;
      end
   end

endmodule : mailbox_fifo

`default_nettype wire

// ### spi_send_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_send_cfg.svh"

module spi_send_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic [`CFG_NUM_SELECTS-1:0] nss_n,
   input wire logic master_role
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // One accepted sensor byte, valid and ready in the same cycle
   sequence take_s;
      sample_valid && sample_ready;
   endsequence
   // A serial clock pulse opens with the rise of sclk
   sequence pulse_s;
      $rose(sclk);
   endsequence

   resp_okay_a: assert property (hresp == 1'b0) else $error("bad response");
   ready_high_a: assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
   read_pad_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
   one_select_a: assert property ($countones(~nss_n) <= 1) else $error("two selects");
   select_hold_a: assert property (!(&nss_n) |=> &nss_n || nss_n == $past(nss_n))
      else $error("select moved");
   idle_lines_a: assert property (&nss_n && $past(&nss_n) |-> !sclk && !mosi)
      else $error("line active");
   slave_quiet_a: assert property (!master_role && $past(!master_role) |-> &nss_n)
      else $error("select in slave role");
   take_drop_a: assert property (take_s |=> !sample_ready) else $error("ready held");
   pulse_len_a: assert property (pulse_s |-> !(&nss_n) ##[1:8] $fell(sclk))
      else $error("clock pulse");
   bit_stable_a: assert property (sclk |-> $stable(mosi)) else $error("data moved");
endmodule : spi_send_checker

`default_nettype wire

// ### spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_send_cfg.svh"

module spi_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic [`CFG_NUM_SELECTS-1:0] nss_n,
   output logic [7:0] rx_cnt,
   output logic [31:0] rx_log
);
   logic [2:0] nbit = 3'h0;
   logic [7:0] shift = 8'h0;
   initial rx_cnt = 8'h0;
   initial rx_log = 32'h0;

   // Capture on rising clock while selected, first bit is the top bit
   always @(posedge sclk) begin
      if (!(&nss_n)) begin
         shift = {shift[6:0], mosi};
         nbit = nbit + 3'h1;
         if (nbit == 3'h0) begin
            rx_log = {rx_log[23:0], shift};
            rx_cnt = rx_cnt + 8'h1;
         end
      end
   end
   // Frame end drops any partial byte
   always @(posedge (&nss_n)) nbit = 3'h0;
endmodule : spi_slave_model

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_send_cfg.svh"

module tb_top;
   typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] d; logic [7:0] e;} row_t;
   // Reset values, unused bits, read-only and unmapped places
   localparam row_t ROWS [8] = '{
      '{1'b0, `CFG_IDX_STATUS, 8'h00, 8'h03}, '{1'b0, `CFG_IDX_SEND, 8'h00, 8'h00},
      '{1'b0, `CFG_IDX_MODE, 8'h00, 8'h90}, '{1'b0, `CFG_IDX_LSB, 8'h00, 8'h00},
      '{1'b1, `CFG_IDX_SEND, 8'hfe, 8'h00}, '{1'b1, `CFG_IDX_STATUS, 8'hff, 8'h03},
      '{1'b1, 8'hff, 8'hff, 8'h00}, '{1'b1, `CFG_IDX_LSB, 8'h5a, 8'h5a}};
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, link_clk = 1'b0;
   logic sample_valid = 1'b0, samp_en = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = `CFG_HSIZE_WORD;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, rx_log;
   logic hreadyout, hresp, sample_ready, sclk, mosi, master_role;
   logic [7:0] sample_data = 8'h20, rx_cnt;
   logic [`CFG_NUM_SELECTS-1:0] nss_n;
   int err_total = 0, num_checks = 0;

   always #12.5 hclk = ~hclk;
   always #100 link_clk = ~link_clk;
   // Sensor source: data only advances on a handshake
   always @(posedge hclk) begin
      sample_valid <= samp_en;
      if (sample_valid && sample_ready) sample_data <= sample_data + 8'h1;
   end

   spi_master_send_control spi_master_send_control_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link_clk(link_clk), .sample_valid(sample_valid),
      .sample_data(sample_data), .sample_ready(sample_ready), .sclk(sclk), .mosi(mosi),
      .nss_n(nss_n), .master_role(master_role));
   spi_slave_model spi_slave_model_i (.sclk(sclk), .mosi(mosi), .nss_n(nss_n),
      .rx_cnt(rx_cnt), .rx_log(rx_log));

   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   // Bounded wait for the slave to accept a phase
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      // Judge by the answer itself so a late but valid ready is not failed
      if (hreadyout !== 1'b1) begin
         chk(32'h0, 32'h1);
         end_of_test();
      end
   endtask : wait_rdy
   // One single word transfer; read data lands in q
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata;
   endtask : bus
   task automatic wait_cnt(input logic [7:0] n);
      int k;
      k = 0;
      while (rx_cnt !== n && k < 3000) begin
         @(posedge hclk);
         k++;
      end
      if (rx_cnt !== n) begin
         chk(rx_cnt, n);
         end_of_test();
      end
   endtask : wait_cnt

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(2);
      for (int i = 0; i < 8; i++) begin
         bus(ROWS[i].wr, ROWS[i].idx, ROWS[i].d);
         if (ROWS[i].wr) bus(1'b0, ROWS[i].idx, 8'h0);
         chk(q, {24'h0, ROWS[i].e});
      end
      // Mailbox bytes queued before send, one more added once status reads idle
      bus(1'b1, `CFG_IDX_MODE, 8'h03);
      bus(1'b1, `CFG_IDX_QUEUE, 8'ha5);
      bus(1'b1, `CFG_IDX_QUEUE, 8'h3c);
      bus(1'b1, `CFG_IDX_SEND, 8'h01);
      cyc(40);
      chk(nss_n, 3'b101);
      chk(master_role, 1'b1);
      bus(1'b0, `CFG_IDX_STATUS, 8'h0);
      chk(q, 32'h0);
      wait_cnt(8'd2);
      cyc(20);
      bus(1'b0, `CFG_IDX_STATUS, 8'h0);
      chk(q, 32'h1);
      bus(1'b1, `CFG_IDX_QUEUE, 8'h81);
      wait_cnt(8'd3);
      chk(rx_log[23:0], 24'ha53c81);
      cyc(20);
      bus(1'b1, `CFG_IDX_SEND, 8'h00);
      cyc(4);
      chk(nss_n, 3'b111);
      bus(1'b0, `CFG_IDX_STATUS, 8'h0);
      chk(q, 32'h3);
      // Burst of three sensor bytes, source stalled at first
      bus(1'b1, `CFG_IDX_LSB, 8'h03);
      bus(1'b1, `CFG_IDX_MODE, 8'h05);
      bus(1'b1, `CFG_IDX_KICK, 8'h00);
      bus(1'b1, `CFG_IDX_SEND, 8'h01);
      cyc(60);
      samp_en <= 1'b1;
      wait_cnt(8'd6);
      chk(rx_log[23:0], 24'h202122);
      cyc(300);
      chk(rx_cnt, 32'd6);
      chk(nss_n, 3'b011);
      chk(sample_ready, 1'b0);
      bus(1'b1, `CFG_IDX_SEND, 8'h00);
      samp_en <= 1'b0;
      // Select zero, then the reserved code that drives no line
      bus(1'b1, `CFG_IDX_MODE, 8'h01);
      bus(1'b1, `CFG_IDX_SEND, 8'h01);
      cyc(10);
      chk(nss_n, 3'h6);
      bus(1'b1, `CFG_IDX_SEND, 8'h00);
      bus(1'b1, `CFG_IDX_MODE, 8'h07);
      bus(1'b1, `CFG_IDX_SEND, 8'h01);
      cyc(10);
      chk(nss_n, 3'h7);
      bus(1'b1, `CFG_IDX_SEND, 8'h00);
      // A byte-sized write must leave the burst length untouched
      hsize <= 3'h0;
      bus(1'b1, `CFG_IDX_LSB, 8'h11);
      hsize <= `CFG_HSIZE_WORD;
      bus(1'b0, `CFG_IDX_LSB, 8'h0);
      chk(q, 32'h3);
      // Slave role keeps every select released
      bus(1'b1, `CFG_IDX_MODE, 8'h02);
      bus(1'b1, `CFG_IDX_SEND, 8'h01);
      cyc(20);
      chk(nss_n, 3'b111);
      chk(master_role, 1'b0);
      bus(1'b1, `CFG_IDX_SEND, 8'h00);
      end_of_test();
   end
endmodule : tb_top

bind spi_master_send_control spi_send_checker spi_send_checker_i (.hclk(hclk),
   .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sample_valid(sample_valid), .sample_ready(sample_ready), .sclk(sclk), .mosi(mosi),
   .nss_n(nss_n), .master_role(master_role));

`default_nettype wire
